// File: core/rss_pkg.sv
// shared constants, field layout and types for the reset and start-up sequencer
package rss_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_MHZ = 250;
    localparam int PUP_DELAY_MS = 72;
    localparam int INTOSC_HZ = 32000; // internal osc rate, plain default
    localparam int PUP_TICKS = PUP_DELAY_MS * INTOSC_HZ / 1000;
    localparam int OSC_START_CYCLES = 1024;
    localparam int BROWN_MIN_US = 100;
    localparam int BROWN_MIN_CYC = BROWN_MIN_US * MCLK_MHZ;
    localparam int PIN_FILT_NS = 100;
    localparam int PIN_FILT_CYC = (PIN_FILT_NS * MCLK_MHZ + 999) / 1000;
    localparam int CNT_W = 24;
    localparam int REL_STAGES = 2;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam int CTRL_OSC_LO = 0;
    localparam int CTRL_PUP_EN = 2;
    localparam int CTRL_BROWN_EN = 3;
    localparam logic [3:0] CTRL_RESET = 4'hF;
    localparam int STAT_EXPIRY = 0;
    localparam int STAT_PDOWN = 1;
    localparam int STAT_PON = 2;
    localparam int STAT_BROWN = 3;
    localparam int STAT_CAUSE = 4;
    localparam int STAT_STATE = 7;
    localparam int STAT_SLEEP = 9;

    typedef enum logic [1:0] {
        LOW_POWER_CRYSTAL_MODE = 2'h0,
        STANDARD_CRYSTAL_MODE = 2'h1,
        HIGH_SPEED_CRYSTAL_MODE = 2'h2,
        RESISTOR_CAPACITOR_MODE = 2'h3
    } rss_osc_e;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_POWER_ON = 3'h1,
        CAUSE_PIN_RUN = 3'h2,
        CAUSE_PIN_SLEEP = 3'h3,
        CAUSE_WATCHDOG_RUN = 3'h4,
        CAUSE_WATCHDOG_WAKE = 3'h5,
        CAUSE_BROWNOUT = 3'h6
    } rss_cause_e;

    // gray coded along supply wait, power-up, osc start, run
    typedef enum logic [1:0] {
        ST_SUPPLY_WAIT = 2'b00,
        ST_PUP = 2'b01,
        ST_OSC_START = 2'b11,
        ST_RUN = 2'b10
    } rss_state_e;

    // any of the three crystal modes
    function automatic logic isCrystal(input rss_osc_e mode);
        return mode != RESISTOR_CAPACITOR_MODE;
    endfunction

endpackage

// File: core/rss_filt_if.sv
// raw and filtered level between the sequencer and a glitch filter
`timescale 1ns/1ps
interface rss_filt_if;
    logic raw;
    logic clean;
    modport src (output raw, input clean);
    modport flt (input raw, output clean);
endinterface

// File: core/rss_glitch_filter.sv
// glitch filter: output follows input only after a steady run of COUNT cycles
`timescale 1ns/1ps
module rss_glitch_filter #(
    parameter int COUNT = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filtered level
    rss_filt_if.flt port
);
    localparam int W = $clog2(COUNT + 1);

    logic [W-1:0] run;

    // ------------------------------------------------------------
    // run counter
    // ------------------------------------------------------------
    // any return to the old level restarts the count, so pulses are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= '0;
            port.clean <= 1'b0;
        end else if (port.raw == port.clean) begin
            run <= '0;
        end else if (run == W'(COUNT - 1)) begin
            run <= '0;
            port.clean <= port.raw;
        end else begin
            run <= run + 1'b1;
        end
    end
endmodule

// File: core/rss_release_sync.sv
// reset release stage: asserts at once, releases after a few clean edges
`timescale 1ns/1ps
module rss_release_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // hold request and released reset
    input wire logic holdReq,
    output logic release_n
);
    logic [rss_pkg::REL_STAGES-1:0] stage;

    // ------------------------------------------------------------
    // release shifter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
        end else if (holdReq) begin
            stage <= '0;
        end else begin
            stage <= {stage[rss_pkg::REL_STAGES-2:0], 1'b1};
        end
    end

    assign release_n = stage[rss_pkg::REL_STAGES-1];
endmodule

// File: core/rss_sequencer.sv
// reset and start-up sequencer with wishbone register slave
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module rss_sequencer #(
    parameter int PUP_TICKS = rss_pkg::PUP_TICKS,
    parameter int BROWN_MIN_CYC = rss_pkg::BROWN_MIN_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // supply monitors
    input wire logic powerOnPulse,
    input wire logic supplyBelowThreshold,
    // external reset pin, low means reset
    input wire logic externalResetPinIn,
    output logic externalResetPinOut,
    output logic externalResetPinOe,
    // watchdog and sleep control from the core
    input wire logic watchdogExpire,
    input wire logic watchdogClear,
    input wire logic sleepEnter,
    // timing sources
    input wire logic oscillatorInputPin,
    input wire logic pupOscIn,
    // core side
    output logic coreReset_n,
    output logic coreRun,
    output logic registerLoad,
    output logic coldStart,
    output logic sleeping,
    output logic [2:0] resetCause
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    rss_filt_if pinIf ();
    rss_filt_if supIf ();

    rss_pkg::rss_state_e state;
    rss_pkg::rss_state_e next_state;
    rss_pkg::rss_osc_e oscSelect;
    logic powerUpTimerEnableBit;
    logic brownoutEnableBit;
    logic expiryFlag;
    logic powerdownFlag;
    logic powerOnFlag;
    logic brownoutFlag;
    logic [rss_pkg::CNT_W-1:0] pupCount;
    logic [rss_pkg::CNT_W-1:0] oscCount;
    logic oscPrev;
    logic pupPrev;
    logic pinLowPrev;
    logic supLowPrev;
    logic oscStartArmed;
    logic wakeMode;
    logic watchdogHold;
    logic relOut;
    logic oscTick;
    logic pupTick;
    logic pinLow;
    logic supLow;
    logic pinFall;
    logic brownFall;
    logic watchdogReset;
    logic watchdogWake;
    logic pupNeeded;
    logic pupDone;
    logic oscDone;
    logic holdReq;
    logic wbReq;
    logic wbWrite;
    logic [31:0] readValue;
    rss_pkg::rss_cause_e next_cause;

    // rising edge of a sampled clock-like input
    function automatic logic risingEdge(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    // pin is inverted so the filter works on "reset requested"
    assign pinIf.raw = ~externalResetPinIn;
    assign supIf.raw = supplyBelowThreshold;

    rss_glitch_filter #(
        .COUNT(rss_pkg::PIN_FILT_CYC)
    ) pinFilter (
        .clk(mclk),
        .rst_n(rst_n),
        .port(pinIf)
    );

    rss_glitch_filter #(
        .COUNT(BROWN_MIN_CYC)
    ) supFilter (
        .clk(mclk),
        .rst_n(rst_n),
        .port(supIf)
    );

    // edge history of the timing sources and filtered levels
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oscPrev <= 1'b0;
            pupPrev <= 1'b0;
            pinLowPrev <= 1'b0;
            supLowPrev <= 1'b0;
        end else begin
            oscPrev <= oscillatorInputPin;
            pupPrev <= pupOscIn;
            pinLowPrev <= pinLow;
            supLowPrev <= supLow;
        end
    end

    // same pin counts a crystal or a driven clock alike
    assign oscTick = risingEdge(oscillatorInputPin, oscPrev);
    assign pupTick = risingEdge(pupOscIn, pupPrev);
    assign pinLow = pinIf.clean;
    assign supLow = supIf.clean & brownoutEnableBit;
    assign pinFall = pinLow & ~pinLowPrev;
    assign brownFall = supLow & ~supLowPrev;
    assign watchdogReset = watchdogExpire & ~sleeping;
    assign watchdogWake = watchdogExpire & sleeping;

    // ------------------------------------------------------------
    // sequence control
    // ------------------------------------------------------------
    // the power-up enable bit is active low; brownout forces it on
    assign pupNeeded = ~powerUpTimerEnableBit | brownoutEnableBit;
    assign pupDone = pupTick && pupCount == rss_pkg::CNT_W'(PUP_TICKS - 1);
    assign oscDone = oscTick &&
        oscCount == rss_pkg::CNT_W'(rss_pkg::OSC_START_CYCLES - 1);

    // next state; power-on wins, then a live brownout
    always_comb begin
        next_state = state;
        if (powerOnPulse) begin
            if (supLow) begin
                next_state = rss_pkg::ST_SUPPLY_WAIT;
            end else if (pupNeeded) begin
                next_state = rss_pkg::ST_PUP;
            end else if (rss_pkg::isCrystal(oscSelect)) begin
                next_state = rss_pkg::ST_OSC_START;
            end else begin
                next_state = rss_pkg::ST_RUN;
            end
        end else if (supLow) begin
            next_state = rss_pkg::ST_SUPPLY_WAIT;
        end else begin
            case (state)
                rss_pkg::ST_SUPPLY_WAIT: begin
                    next_state = rss_pkg::ST_PUP;
                end
                rss_pkg::ST_PUP: begin
                    if (pupDone) begin
                        next_state = oscStartArmed ? rss_pkg::ST_OSC_START
                                                   : rss_pkg::ST_RUN;
                    end
                end
                rss_pkg::ST_OSC_START: begin
                    if (oscDone) begin
                        next_state = rss_pkg::ST_RUN;
                    end
                end
                rss_pkg::ST_RUN: begin
                    if (watchdogWake && rss_pkg::isCrystal(oscSelect)) begin
                        next_state = rss_pkg::ST_OSC_START;
                    end
                end
                default: begin
                    next_state = rss_pkg::ST_SUPPLY_WAIT;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rss_pkg::ST_SUPPLY_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // after the power-up timer, osc start only follows power-on, never a brownout path
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oscStartArmed <= 1'b0;
        end else if (powerOnPulse) begin
            oscStartArmed <= rss_pkg::isCrystal(oscSelect);
        end else if (brownFall) begin
            oscStartArmed <= 1'b0;
        end
    end

    // wake from sleep waits on the oscillator without resetting the core
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wakeMode <= 1'b0;
        end else if (powerOnPulse || supLow) begin
            wakeMode <= 1'b0;
        end else if (state == rss_pkg::ST_RUN && watchdogWake) begin
            wakeMode <= rss_pkg::isCrystal(oscSelect);
        end else if (state != rss_pkg::ST_OSC_START) begin
            wakeMode <= 1'b0;
        end
    end

    // power-up count restarts from zero on every entry
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pupCount <= '0;
        end else if (powerOnPulse || state != rss_pkg::ST_PUP
                || next_state != rss_pkg::ST_PUP) begin
            pupCount <= '0;
        end else if (pupTick) begin
            pupCount <= pupCount + 1'b1;
        end
    end

    // oscillator start count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oscCount <= '0;
        end else if (powerOnPulse || state != rss_pkg::ST_OSC_START) begin
            oscCount <= '0;
        end else if (oscTick) begin
            oscCount <= oscCount + 1'b1;
        end
    end

    // watchdog reset is an internal one-cycle hold only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            watchdogHold <= 1'b0;
        end else begin
            watchdogHold <= watchdogReset;
        end
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // a pin held low past the timeouts lets go once the glitch filter sees it high, without rerunning the timeouts
    assign holdReq = (state != rss_pkg::ST_RUN && !wakeMode) || powerOnPulse
        || pinLow || watchdogHold;

    rss_release_sync releaseSync (
        .clk(mclk),
        .rst_n(rst_n),
        .holdReq(holdReq),
        .release_n(relOut)
    );

    // core outputs, each from its own flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            coreReset_n <= 1'b0;
            coreRun <= 1'b0;
        end else begin
            coreReset_n <= relOut;
            coreRun <= relOut && state == rss_pkg::ST_RUN && !sleeping;
        end
    end

    // reset class strobes for the rest of the chip
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            registerLoad <= 1'b0;
            coldStart <= 1'b0;
        end else begin
            registerLoad <= powerOnPulse | brownFall | pinFall | watchdogReset;
            coldStart <= powerOnPulse;
        end
    end

    // the pin is input only; internal resets never pull it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            externalResetPinOut <= 1'b0;
            externalResetPinOe <= 1'b0;
        end else begin
            externalResetPinOut <= 1'b0;
            externalResetPinOe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // reset cause and status flags
    // ------------------------------------------------------------
    always_comb begin
        if (powerOnPulse) begin
            next_cause = rss_pkg::CAUSE_POWER_ON;
        end else if (brownFall) begin
            next_cause = rss_pkg::CAUSE_BROWNOUT;
        end else if (pinFall) begin
            next_cause = sleeping ? rss_pkg::CAUSE_PIN_SLEEP : rss_pkg::CAUSE_PIN_RUN;
        end else if (watchdogExpire) begin
            next_cause = sleeping ? rss_pkg::CAUSE_WATCHDOG_WAKE
                                  : rss_pkg::CAUSE_WATCHDOG_RUN;
        end else begin
            next_cause = rss_pkg::rss_cause_e'(resetCause);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resetCause <= rss_pkg::CAUSE_NONE;
        end else begin
            resetCause <= next_cause;
        end
    end

    // expiry/powerdown pair; reset events outrank core commands
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            expiryFlag <= 1'b1;
            powerdownFlag <= 1'b1;
        end else if (powerOnPulse || brownFall) begin
            expiryFlag <= 1'b1;
            powerdownFlag <= 1'b1;
        end else if (pinFall) begin
            if (sleeping) begin
                expiryFlag <= 1'b1;
                powerdownFlag <= 1'b0;
            end
        end else if (watchdogExpire) begin
            expiryFlag <= 1'b0;
            powerdownFlag <= ~sleeping;
        end else if (watchdogClear) begin
            expiryFlag <= 1'b1;
            powerdownFlag <= 1'b1;
        end else if (sleepEnter) begin
            expiryFlag <= 1'b1;
            powerdownFlag <= 1'b0;
        end
    end

    // sleep state, left by any reset or wake
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleeping <= 1'b0;
        end else if (powerOnPulse || brownFall || pinFall || watchdogExpire) begin
            sleeping <= 1'b0;
        end else if (sleepEnter) begin
            sleeping <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // ack one cycle after the request; write lands on the acked edge
    assign wbReq = wb_cyc_i & wb_stb_i;
    assign wbWrite = wbReq & wb_we_i & wb_ack_o & wb_sel_i[0];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wbReq & ~wb_ack_o;
        end
    end

    // configuration; held through every device reset, only rst_n loads it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oscSelect <= rss_pkg::rss_osc_e'(rss_pkg::CTRL_RESET[1:0]);
            powerUpTimerEnableBit <= rss_pkg::CTRL_RESET[rss_pkg::CTRL_PUP_EN];
            brownoutEnableBit <= rss_pkg::CTRL_RESET[rss_pkg::CTRL_BROWN_EN];
        end else if (wbWrite && wb_adr_i == rss_pkg::ADDR_CTRL) begin
            oscSelect <= rss_pkg::rss_osc_e'(
                wb_dat_i[rss_pkg::CTRL_OSC_LO +: 2]);
            powerUpTimerEnableBit <= wb_dat_i[rss_pkg::CTRL_PUP_EN];
            brownoutEnableBit <= wb_dat_i[rss_pkg::CTRL_BROWN_EN];
        end
    end

    // power-on flag: hardware clear wins over a software write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            powerOnFlag <= 1'b0;
        end else if (powerOnPulse) begin
            powerOnFlag <= 1'b0;
        end else if (wbWrite && wb_adr_i == rss_pkg::ADDR_STAT) begin
            powerOnFlag <= wb_dat_i[rss_pkg::STAT_PON];
        end
    end

    // brownout flag: meaningless while brownout is disabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            brownoutFlag <= 1'b0;
        end else if (brownFall) begin
            brownoutFlag <= 1'b0;
        end else if (wbWrite && wb_adr_i == rss_pkg::ADDR_STAT) begin
            brownoutFlag <= wb_dat_i[rss_pkg::STAT_BROWN];
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        readValue = '0;
        case (wb_adr_i)
            rss_pkg::ADDR_CTRL: begin
                readValue[rss_pkg::CTRL_OSC_LO +: 2] = oscSelect;
                readValue[rss_pkg::CTRL_PUP_EN] = powerUpTimerEnableBit;
                readValue[rss_pkg::CTRL_BROWN_EN] = brownoutEnableBit;
            end
            rss_pkg::ADDR_STAT: begin
                readValue[rss_pkg::STAT_EXPIRY] = expiryFlag;
                readValue[rss_pkg::STAT_PDOWN] = powerdownFlag;
                readValue[rss_pkg::STAT_PON] = powerOnFlag;
                readValue[rss_pkg::STAT_BROWN] = brownoutFlag;
                readValue[rss_pkg::STAT_CAUSE +: 3] = resetCause;
                readValue[rss_pkg::STAT_STATE +: 2] = state;
                readValue[rss_pkg::STAT_SLEEP] = sleeping;
            end
            default: begin
                readValue = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= '0;
        end else if (wbReq && !wb_ack_o) begin
            wb_dat_o <= readValue;
        end
    end

endmodule

// File: verif/rss_sequencer_assertions.sv
// port checker for the reset and start-up sequencer
`timescale 1ns/1ps
module rss_sequencer_assertions (
    input wire logic mclk, rst_n, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic externalResetPinIn, externalResetPinOe, supplyBelowThreshold,
    input wire logic coreReset_n, coreRun, registerLoad, coldStart,
    input wire logic [2:0] resetCause
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [5:0] pinLow;
    // low-pin run length, saturating so a long hold never wraps
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) pinLow <= 6'h00;
        else if (externalResetPinIn) pinLow <= 6'h00;
        else if (pinLow != 6'h3F) pinLow <= pinLow + 6'h01;
    end
    pin_undriven_a:
        assert property (!externalResetPinOe) else $error("pin driven");
    run_in_reset_a:
        assert property (coreRun |-> coreReset_n) else $error("run in reset");
    cold_cause_a:
        assert property (coldStart |-> registerLoad && resetCause == 3'h1) else $error("cold");
    wake_no_load_a:
        assert property (registerLoad |-> resetCause != 3'h5) else $error("wake load");
    pin_filter_a:
        assert property (registerLoad && resetCause == 3'h2 |-> !$past(externalResetPinIn, 25))
        else $error("short pin");
    brown_min_a:
        assert property (registerLoad && resetCause == 3'h6 |-> $past(supplyBelowThreshold, 10))
        else $error("short dip");
    pin_hold_a:
        assert property (pinLow >= 6'h20 |-> !coreReset_n) else $error("pin hold");
    bus_ack_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack");
    cover property ($rose(coreRun));
    cover property (registerLoad && resetCause == 3'h6);
    cover property (resetCause == 3'h5);
endmodule
bind rss_sequencer rss_sequencer_assertions u_rss_sequencer_assertions (.*);

// File: verif/rss_supply_model.sv
// supply monitor, reset pin and oscillator model facing the sequencer
`timescale 1ns/1ps
module rss_supply_model (
    // clock
    input wire logic mclk,
    // monitor events, pulled-up pin and oscillators
    output logic powerOnPulse = 1'b0,
    output logic supplyBelow = 1'b0,
    output logic pinLevel = 1'b1,
    output logic oscLevel = 1'b0,
    output logic pupLevel = 1'b0
);
    // fast free-running oscillators keep the long counts short
    always @(posedge mclk) oscLevel <= ~oscLevel;
    always @(posedge mclk) pupLevel <= ~pupLevel;
    task automatic power_on();
        @(posedge mclk);
        powerOnPulse <= 1'b1;
        @(posedge mclk);
        powerOnPulse <= 1'b0;
    endtask
    // pin returns to its pull-up level once released
    task automatic pin_low(input int n);
        @(posedge mclk);
        pinLevel <= 1'b0;
        repeat (n) @(posedge mclk);
        pinLevel <= 1'b1;
    endtask
    task automatic dip(input int n);
        @(posedge mclk);
        supplyBelow <= 1'b1;
        repeat (n) @(posedge mclk);
        supplyBelow <= 1'b0;
    endtask
endmodule

// File: verif/rss_sequencer_bench.sv
// self-checking bench for the reset and start-up sequencer
`timescale 1ns/1ps
module rss_sequencer_bench;
    logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic wdExp = 1'b0, slp = 1'b0, wdClr = 1'b0, pon, below, pin, osc, pup, ack, rstOut, run;
    logic load, cold, sleepOut, pinOe;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, st;
    logic [2:0] cause;
    int errors = 0, check_count = 0, cycles = 0, n;
    always #2 mclk = ~mclk;
    rss_supply_model u_rss_supply_model (.mclk(mclk), .powerOnPulse(pon),
        .supplyBelow(below), .pinLevel(pin), .oscLevel(osc), .pupLevel(pup));
    rss_sequencer #(.PUP_TICKS(8), .BROWN_MIN_CYC(10)) u_rss_sequencer (.mclk(mclk),
        .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .powerOnPulse(pon),
        .supplyBelowThreshold(below), .externalResetPinIn(pin), .externalResetPinOut(),
        .externalResetPinOe(pinOe), .watchdogExpire(wdExp), .watchdogClear(wdClr),
        .sleepEnter(slp), .oscillatorInputPin(osc), .pupOscIn(pup), .coreReset_n(rstOut),
        .coreRun(run), .registerLoad(load), .coldStart(cold), .sleeping(sleepOut),
        .resetCause(cause));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // classic single cycle; read data taken at the ack edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge mclk); while (ack !== 1'b1);
        st = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wrel();
        n = 0;
        while (rstOut !== 1'b1) begin
            @(posedge mclk);
            n++;
        end
    endtask
    // cause, brown flag, power-on flag, powerdown, expiry
    task automatic stat(input logic [6:0] e);
        bus(1'b0, 8'h04, 32'h0);
        chk(st[6:0], e);
    endtask
    task automatic t_cold();
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h04, 32'hC);
        u_rss_supply_model.power_on();
        @(posedge mclk);
        chk({cold, load}, 2'h3);
        repeat (2) @(posedge mclk);
        wrel();
        chk(n > 2064, 1);
        chk(run, 1);
        bus(1'b0, 8'h04, 32'h0);
        chk({st[8:4], st[2:0]}, {2'h2, 3'h1, 3'h3});
        bus(1'b1, 8'h04, 32'hC);
        $display("cold start done");
    endtask
    task automatic t_pin();
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk(st[3:0], 4'h0);
        u_rss_supply_model.pin_low(10);
        repeat (30) @(posedge mclk);
        chk(rstOut, 1);
        u_rss_supply_model.pin_low(40);
        wrel();
        chk(n < 32, 1);
        stat(7'h2F);
        $display("pin reset done");
    endtask
    task automatic t_brown();
        bus(1'b1, 8'h00, 32'h7);
        u_rss_supply_model.power_on();
        repeat (2) @(posedge mclk);
        wrel();
        chk(n < 6, 1);
        bus(1'b1, 8'h04, 32'hC);
        u_rss_supply_model.dip(30);
        repeat (15) @(posedge mclk);
        chk(rstOut, 1);
        bus(1'b1, 8'h00, 32'hF);
        u_rss_supply_model.dip(4);
        repeat (15) @(posedge mclk);
        chk(rstOut, 1);
        u_rss_supply_model.dip(30);
        wrel();
        chk(n > 16 && n < 100, 1);
        stat(7'h67);
        $display("brownout done");
    endtask
    task automatic t_wdog();
        wdExp <= 1'b1;
        @(posedge mclk);
        wdExp <= 1'b0;
        @(posedge mclk);
        chk(load, 1);
        repeat (2) @(posedge mclk);
        wrel();
        chk(pinOe, 0);
        stat(7'h46);
        bus(1'b1, 8'h00, 32'hA);
        slp <= 1'b1;
        @(posedge mclk);
        slp <= 1'b0;
        wdExp <= 1'b1;
        @(posedge mclk);
        wdExp <= 1'b0;
        chk(sleepOut, 1);
        @(posedge mclk);
        chk({load, sleepOut}, 2'h0);
        repeat (4) @(posedge mclk);
        chk(rstOut, 1);
        chk(run, 0);
        chk(cause, 3'h5);
        stat(7'h54);
        wdClr <= 1'b1;
        @(posedge mclk);
        wdClr <= 1'b0;
        stat(7'h57);
        repeat (2100) @(posedge mclk);
        chk(run, 1);
        $display("watchdog done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_cold();
        t_pin();
        t_brown();
        t_wdog();
        close_out();
    end
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
endmodule
